// >>> hw/glitch_free_gate.sv
`default_nettype none
// Latch-based clock gate: the enable is held while the clock is high, so a
// change of the enable can never cut a high phase short.
module glitch_free_gate (
	input wire logic clkIn,
	input wire logic enable,
	output logic clkOut
);
	// Transparent-low latch holding the enable across the high phase.
	logic enLatch;

	// Enable only passes while the clock is low.
	always_latch begin
		if (!clkIn) begin
			enLatch <= enable;
		end
	end

	// Gated clock output.
	assign clkOut = clkIn & enLatch;
endmodule : glitch_free_gate
`default_nettype wire

// >>> hw/pcg_pkg.sv
`default_nettype none
package pcg_pkg;
	// Register byte offsets.
	localparam logic [11:0] RUN_GROUP0_OFS = 12'h100;
	localparam logic [11:0] RUN_GROUP1_OFS = 12'h104;
	localparam logic [11:0] SLEEP_GROUP0_OFS = 12'h110;
	localparam logic [11:0] DEEP_GROUP0_OFS = 12'h120;
	localparam logic [11:0] RUN_CFG_OFS = 12'h060;
	// Group-0 field positions.
	localparam int CONV_BIT = 16;
	localparam int SPD_LSB = 8;
	localparam int HIBER_BIT = 6;
	localparam int WDOG_BIT = 3;
	// Group-1 field positions.
	localparam int TMR2_BIT = 18;
	localparam int TMR1_BIT = 17;
	localparam int TMR0_BIT = 16;
	localparam int TW1_BIT = 14;
	localparam int TW0_BIT = 12;
	localparam int SSP0_BIT = 4;
	localparam int ASP1_BIT = 1;
	localparam int ASP0_BIT = 0;
	// Automatic gating select bit in the run clock configuration.
	localparam int AUTO_GATE_BIT = 27;
	// Writable masks and reset values.
	localparam logic [31:0] RUN0_MASK = 32'h0001_0348;
	localparam logic [31:0] SLEEP0_MASK = 32'h0001_0348;
	localparam logic [31:0] DEEP0_MASK = 32'h0001_0048;
	localparam logic [31:0] GRP1_MASK = 32'h0007_5013;
	localparam logic [31:0] CFG_MASK = 32'h0800_0000;
	localparam logic [31:0] GRP0_RESET = 32'h0000_0040;
	localparam logic [31:0] GRP1_RESET = 32'h0000_0000;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	// Number of gated units: 3 from group 0, 8 from group 1.
	localparam int NUM_UNITS = 11;
	// Power states.
	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_SLEEP,
		PWR_DEEP
	} pwr_state_e;
endpackage : pcg_pkg
`default_nettype wire

// >>> hw/peripheral_clock_gating.sv
// Register access over APB is this design's own decision.
`default_nettype none
// Operation
// - Each gating bit enables one unit clock.
// - Access to gated unit answers bus fault.
// - Gating bits reset to 0 unless noted.
// - Separate run, sleep, deep-sleep gating sets; the code has these for group 0 only, group 1 has a run set alone.
// - Sleep sets apply only with automatic gating.
// - Bit 16 gates converter module 0.
// - Bits 9:8 select converter sample speed.
// - Bit 6 gates hibernation, resets to 1.
// - Bit 3 gates watchdog, resets to 0.
// - Deep-sleep group 0 has no speed field.
// - Group-1 bits 18:16 gate timers 2..0.
// - Bits 14 and 12 gate two-wire ports.
// - Bit 4 gates synchronous serial port.
// - Bits 1 and 0 gate async ports.
// - Reserved bits read-only, read as zero.
// - Run group-0 at 0x100 applies while running.
module peripheral_clock_gating (
	input wire logic ref_clk,
	input wire logic nrst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Requested power state from the core, same clock domain.
	input wire logic sleepReq,
	input wire logic deepSleepReq,
	// Peripheral access checks: one select per unit, from the fabric.
	input wire logic [pcg_pkg::NUM_UNITS-1:0] unitAccess,
	output logic busFault,
	// Effective enables, registered.
	output logic [pcg_pkg::NUM_UNITS-1:0] unitEnable,
	output logic [1:0] converterSpeed,
	// Gated unit clocks.
	output logic [pcg_pkg::NUM_UNITS-1:0] unitClk
);
	// Software-visible registers.
	logic [31:0] run0_q;
	logic [31:0] run1_q;
	logic [31:0] sleep0_q;
	logic [31:0] deep0_q;
	logic [31:0] cfg_q;
	// Power state derived from the requests.
	pcg_pkg::pwr_state_e pwr_q;
	pcg_pkg::pwr_state_e pwr_d;
	// Selected enable vector before registering.
	logic [pcg_pkg::NUM_UNITS-1:0] enable_d;
	logic [1:0] speed_d;
	// APB access phase strobe.
	logic apbAccess;
	logic apbWrite;
	logic addrHit;

	assign apbAccess = psel & penable;
	assign apbWrite = apbAccess & pwrite;

	// Decode of whether the address maps a register, used once.
	function automatic logic isMapped(input logic [11:0] a);
		isMapped = (a == pcg_pkg::RUN_GROUP0_OFS) ||
			(a == pcg_pkg::RUN_GROUP1_OFS) ||
			(a == pcg_pkg::SLEEP_GROUP0_OFS) ||
			(a == pcg_pkg::DEEP_GROUP0_OFS) ||
			(a == pcg_pkg::RUN_CFG_OFS);
	endfunction : isMapped

	// Group-0 register to unit enables: converter, hibernation, watchdog.
	function automatic logic [2:0] grp0Units(input logic [31:0] r);
		grp0Units = {r[pcg_pkg::CONV_BIT], r[pcg_pkg::HIBER_BIT],
			r[pcg_pkg::WDOG_BIT]};
	endfunction : grp0Units

	// Group-1 register to unit enables, timers down to async ports.
	function automatic logic [7:0] grp1Units(input logic [31:0] r);
		grp1Units = {r[pcg_pkg::TMR2_BIT], r[pcg_pkg::TMR1_BIT],
			r[pcg_pkg::TMR0_BIT], r[pcg_pkg::TW1_BIT],
			r[pcg_pkg::TW0_BIT], r[pcg_pkg::SSP0_BIT],
			r[pcg_pkg::ASP1_BIT], r[pcg_pkg::ASP0_BIT]};
	endfunction : grp1Units

	assign addrHit = isMapped(paddr);

	// Register writes; only writable bits are stored so reserved bits stay
	// zero whatever software writes back.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			run0_q <= pcg_pkg::GRP0_RESET;
			run1_q <= pcg_pkg::GRP1_RESET;
			sleep0_q <= pcg_pkg::GRP0_RESET;
			deep0_q <= pcg_pkg::GRP0_RESET;
			cfg_q <= pcg_pkg::CFG_RESET;
		end else if (apbWrite) begin
			// Each mapped case item updates one register.
			unique case (paddr)
				pcg_pkg::RUN_GROUP0_OFS: begin
					run0_q <= pwdata & pcg_pkg::RUN0_MASK;
				end
				pcg_pkg::RUN_GROUP1_OFS: begin
					run1_q <= pwdata & pcg_pkg::GRP1_MASK;
				end
				pcg_pkg::SLEEP_GROUP0_OFS: begin
					sleep0_q <= pwdata & pcg_pkg::SLEEP0_MASK;
				end
				pcg_pkg::DEEP_GROUP0_OFS: begin
					deep0_q <= pwdata & pcg_pkg::DEEP0_MASK;
				end
				pcg_pkg::RUN_CFG_OFS: begin
					cfg_q <= pwdata & pcg_pkg::CFG_MASK;
				end
				default: begin
					// Unmapped writes are dropped and flagged by pslverr.
				end
			endcase
		end
	end

	// APB answer: zero wait states, read data registered at the end of the setup
	// phase; unmapped addresses give pslverr and zero data.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			// Ready rises in the first access cycle, one cycle after setup.
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~addrHit;
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					pcg_pkg::RUN_GROUP0_OFS: prdata <= run0_q;
					pcg_pkg::RUN_GROUP1_OFS: prdata <= run1_q;
					pcg_pkg::SLEEP_GROUP0_OFS: prdata <= sleep0_q;
					pcg_pkg::DEEP_GROUP0_OFS: prdata <= deep0_q;
					pcg_pkg::RUN_CFG_OFS: prdata <= cfg_q;
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Power state: deep sleep outranks sleep, and neither is honoured
	// unless automatic gating is selected.
	always_comb begin
		pwr_d = pcg_pkg::PWR_RUN;
		if (cfg_q[pcg_pkg::AUTO_GATE_BIT]) begin
			if (deepSleepReq) begin
				pwr_d = pcg_pkg::PWR_DEEP;
			end else if (sleepReq) begin
				pwr_d = pcg_pkg::PWR_SLEEP;
			end
		end
	end

	// Power state register.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			pwr_q <= pcg_pkg::PWR_RUN;
		end else begin
			pwr_q <= pwr_d;
		end
	end

	// Pick the gating set for the present state. Group 1 only has its run
	// register here, so it applies in every state.
	always_comb begin
		unique case (pwr_q)
			pcg_pkg::PWR_SLEEP: begin
				enable_d = {grp0Units(sleep0_q), grp1Units(run1_q)};
				speed_d = sleep0_q[pcg_pkg::SPD_LSB +: 2];
			end
			pcg_pkg::PWR_DEEP: begin
				enable_d = {grp0Units(deep0_q), grp1Units(run1_q)};
				// No speed field in deep sleep: keep the run setting.
				speed_d = run0_q[pcg_pkg::SPD_LSB +: 2];
			end
			default: begin
				enable_d = {grp0Units(run0_q), grp1Units(run1_q)};
				speed_d = run0_q[pcg_pkg::SPD_LSB +: 2];
			end
		endcase
	end

	// Registered enables and converter speed.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			unitEnable <= {3'b010, 8'h00};
			converterSpeed <= 2'h0;
		end else begin
			unitEnable <= enable_d;
			converterSpeed <= speed_d;
		end
	end

	// Fault, a cycle later, when any selected unit's enable in enable_d is clear.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			busFault <= 1'b0;
		end else begin
			busFault <= |(unitAccess & ~enable_d);
		end
	end

	// One glitch-free gate per unit.
	genvar g;
	generate
		for (g = 0; g < pcg_pkg::NUM_UNITS; g++) begin : gen_gate
			glitch_free_gate uGate (
				.clkIn(ref_clk),
				.enable(unitEnable[g]),
				.clkOut(unitClk[g])
			);
		end
	endgenerate

	// Assertions.
	a_fault_on_gated: assert property (@(posedge ref_clk) disable iff (!nrst)
		(|(unitAccess & ~enable_d)) |=> busFault)
		else $error("Access to gated unit gave no fault.");
	a_acg_needed: assert property (@(posedge ref_clk) disable iff (!nrst)
		!cfg_q[pcg_pkg::AUTO_GATE_BIT] |=> pwr_q == pcg_pkg::PWR_RUN)
		else $error("Sleep set applied without automatic gating.");
	a_run_set_used: assert property (@(posedge ref_clk) disable iff (!nrst)
		pwr_q == pcg_pkg::PWR_RUN |=> unitEnable[10] == $past(run0_q[16]))
		else $error("Run set not applied to converter.");
	a_deep_wdog: assert property (@(posedge ref_clk) disable iff (!nrst)
		pwr_q == pcg_pkg::PWR_DEEP |=> unitEnable[8] == $past(deep0_q[3]))
		else $error("Deep-sleep watchdog enable not applied.");
	a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
		(run1_q & ~pcg_pkg::GRP1_MASK) == 32'h0 &&
		(deep0_q[15:7] == 9'h0))
		else $error("Reserved bit became set.");
	a_timer_map: assert property (@(posedge ref_clk) disable iff (!nrst)
		##1 unitEnable[7:5] == $past(run1_q[18:16]))
		else $error("Timer enables misrouted.");
	a_serial_map: assert property (@(posedge ref_clk) disable iff (!nrst)
		##1 unitEnable[4:0] == {$past(run1_q[14]), $past(run1_q[12]),
		$past(run1_q[4]), $past(run1_q[1:0])})
		else $error("Serial enables misrouted.");
	a_reset_values: assert property (@(posedge ref_clk)
		!nrst |=> run0_q == 32'h40 && run1_q == 32'h0 && busFault == 1'b0)
		else $error("Reset values wrong.");
	a_apb_ready: assert property (@(posedge ref_clk) disable iff (!nrst)
		psel && !penable |=> pready ##1 !pready || (psel && !penable))
		else $error("APB ready timing broken.");
	c_sleep_entry: cover property (@(posedge ref_clk) disable iff (!nrst)
		pwr_q == pcg_pkg::PWR_SLEEP);
	c_deep_entry: cover property (@(posedge ref_clk) disable iff (!nrst)
		pwr_q == pcg_pkg::PWR_DEEP);
	c_fault: cover property (@(posedge ref_clk) disable iff (!nrst) busFault);
	c_bad_addr: cover property (@(posedge ref_clk) disable iff (!nrst)
		pready && pslverr);
endmodule : peripheral_clock_gating
`default_nettype wire

// >>> verif/testbench.sv
`default_nettype none
// Compares one value against its expectation and counts the outcome.
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
	mismatches++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	int mismatches = 0; // Failed comparisons.
	int checks_done = 0; // All comparisons made.
	int cycles = 0; // Clock cycles for the hang guard.
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sleepReq = 1'b0;
	logic deepSleepReq = 1'b0;
	logic [10:0] unitAccess = 11'h000;
	logic busFault;
	logic [10:0] unitEnable;
	logic [1:0] converterSpeed;
	logic [10:0] unitClk;
	peripheral_clock_gating i_peripheral_clock_gating (
		.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sleepReq(sleepReq),
		.deepSleepReq(deepSleepReq), .unitAccess(unitAccess),
		.busFault(busFault), .unitEnable(unitEnable),
		.converterSpeed(converterSpeed), .unitClk(unitClk)
	);
	// The clock runs at 10 MHz.
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	// Hang guard: the tests need well under a thousand cycles.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles > 3000) begin
			mismatches++;
			end_sim();
		end
	end
	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	// One APB transfer; the request is held until pready is seen high.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// A slave that never answers counts as a mismatch.
		if (pready !== 1'b1) begin
			mismatches++;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Write with no check; the answer is read back elsewhere.
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	// Read and compare both the data and the error response.
	task automatic rd(input logic [11:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		`CHK(r, x)
		`CHK(e, xe)
	endtask : rd
	// Lets the enable pipeline settle before the outputs are judged.
	task automatic settle();
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : settle
	// Reset values of the four gating registers and of the enable and speed outputs.
	task automatic t_reset();
		rd(pcg_pkg::RUN_GROUP0_OFS, 32'h0000_0040, 1'b0);
		rd(pcg_pkg::RUN_GROUP1_OFS, 32'h0000_0000, 1'b0);
		rd(pcg_pkg::SLEEP_GROUP0_OFS, 32'h0000_0040, 1'b0);
		rd(pcg_pkg::DEEP_GROUP0_OFS, 32'h0000_0040, 1'b0);
		`CHK(unitEnable, 11'h200)
		`CHK(converterSpeed, 2'h0)
		$display("reset test done");
	endtask : t_reset
	// Ones to group 1 and deep sleep, all but bit 9 to sleep: only the documented fields may stick.
	task automatic t_fields();
		wr(pcg_pkg::RUN_GROUP1_OFS, 32'hffff_ffff);
		rd(pcg_pkg::RUN_GROUP1_OFS, 32'h0007_5013, 1'b0);
		wr(pcg_pkg::SLEEP_GROUP0_OFS, 32'hffff_fdff);
		rd(pcg_pkg::SLEEP_GROUP0_OFS, 32'h0001_0148, 1'b0);
		wr(pcg_pkg::DEEP_GROUP0_OFS, 32'hffff_ffff);
		rd(pcg_pkg::DEEP_GROUP0_OFS, 32'h0001_0048, 1'b0);
		// An unmapped place answers an error and reads zero.
		wr(12'h200, 32'hffff_ffff);
		rd(12'h200, 32'h0000_0000, 1'b1);
		$display("field test done");
	endtask : t_fields
	// Sample speed codes; code 3 is left out as above the maximum.
	task automatic t_speed();
		for (int s = 0; s < 3; s++) begin
			wr(pcg_pkg::RUN_GROUP0_OFS, 32'h0000_0040 | (s << 8));
			settle();
			`CHK(converterSpeed, 2'(s))
		end
		$display("speed test done");
	endtask : t_speed
	// Power state picks the gating set; gated access faults.
	task automatic t_power();
		wr(pcg_pkg::RUN_GROUP0_OFS, 32'h0001_0008);
		wr(pcg_pkg::SLEEP_GROUP0_OFS, 32'h0000_0040);
		wr(pcg_pkg::DEEP_GROUP0_OFS, 32'h0000_0008);
		wr(pcg_pkg::RUN_GROUP1_OFS, 32'h0000_0001);
		wr(pcg_pkg::RUN_CFG_OFS, 32'h0000_0000);
		sleepReq <= 1'b1;
		settle();
		`CHK(unitEnable, 11'h501)
		wr(pcg_pkg::RUN_CFG_OFS, 32'h0800_0000);
		settle();
		`CHK(unitEnable, 11'h201)
		deepSleepReq <= 1'b1;
		settle();
		`CHK(unitEnable, 11'h101)
		sleepReq <= 1'b0;
		deepSleepReq <= 1'b0;
		settle();
		`CHK(unitEnable, 11'h501)
		// The clock must be high exactly where the unit is enabled.
		@(posedge ref_clk);
		#20;
		`CHK(unitClk, unitEnable)
		// In the low phase every gated clock must be low too.
		#50;
		`CHK(unitClk, 11'h000)
		@(posedge ref_clk);
		unitAccess <= 11'h200;
		@(posedge ref_clk);
		unitAccess <= 11'h001;
		#1;
		`CHK(busFault, 1'b1)
		@(posedge ref_clk);
		unitAccess <= 11'h000;
		#1;
		`CHK(busFault, 1'b0)
		$display("power test done");
	endtask : t_power
	// Main sequence: reset for two cycles, then the tests.
	initial begin
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		t_reset();
		t_fields();
		t_speed();
		t_power();
		end_sim();
	end
endmodule : testbench
`default_nettype wire
